// ---- hdl/iocc_pkg.sv ----
// Shared constants and types for the channel conditioning block.
// Assumes one clock domain and fixed-point configuration values.
package iocc_pkg;

    localparam int ANA_W         = 16;
    localparam int FRAC_W        = 16;
    localparam int FIX_W         = 32;
    localparam int DMP_W         = 16;

    localparam logic [2:0] RANGE_NONE   = 3'h0;
    localparam logic [2:0] RANGE_CUST_LO = 3'h4;
    localparam logic [2:0] RANGE_CUST_HI = 3'h6;
    localparam logic [2:0] RANGE_RST    = 3'h2;

    localparam logic signed [FIX_W-1:0] OFFSET_RST = 32'sh0000_0000;
    localparam logic signed [FIX_W-1:0] WEIGHT_RST = 32'sh0001_0000;
    localparam logic [DMP_W-1:0]        DAMP_RST   = 16'hC000;

    localparam logic [7:0] DEBOUNCE_RST = 8'h08;
    localparam logic [7:0] DEBOUNCE_MIN = 8'h01;
    localparam logic       PULLUP_RST   = 1'h1;

    localparam logic [1:0] DI_NONE  = 2'h0;
    localparam logic [1:0] DI_PLAIN = 2'h1;
    localparam logic [1:0] DI_PULSE = 2'h2;

    localparam logic [1:0] OUT_OPEN   = 2'h0;
    localparam logic [1:0] OUT_CLOSED = 2'h1;
    localparam logic [1:0] MAP1_RST   = 2'h1;
    localparam logic [1:0] MAP0_RST   = 2'h1;
    localparam logic       ACT_RST    = 1'h1;
    localparam logic [3:0] SRC_RST    = 4'h8;
    localparam logic [31:0] PULSE_RST = 32'h0000_0001;

    localparam int CNT_W = 32;

    typedef enum {
        IOCC_IDLE,
        IOCC_HOLD
    } iocc_out_state_t;

endpackage : iocc_pkg

// ---- hdl/iocc_debounce.sv ----
// Debounce and pulse counting for one digital input.
// Assumes the raw pin is already synchronised to clk.
`timescale 1ns/10ps
module iocc_debounce
    import iocc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       pin_sync,
    input  wire logic [1:0] in_type,
    input  wire logic [7:0] debounce_cnt,
    output logic            level,
    output logic [CNT_W-1:0] pulse_count
);

    logic [7:0]       run_reg;
    logic             level_reg;
    logic             prev_reg;
    logic [CNT_W-1:0] pcnt_reg;

    wire logic       is_plain = (in_type == DI_PLAIN);
    wire logic       is_pulse = (in_type == DI_PULSE);
    wire logic [7:0] limit    = (debounce_cnt < DEBOUNCE_MIN) ? DEBOUNCE_MIN : debounce_cnt;
    wire logic       differs  = (pin_sync != level_reg);
    wire logic       settle   = differs && ((run_reg + 8'h01) >= limit);
    wire logic       rise     = pin_sync && !prev_reg;

    // Both edge directions share one counter, so a glitch restarts it.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_reg   <= 8'h00;
            level_reg <= 1'b0;
        end else if (!is_plain) begin
            run_reg   <= 8'h00;
            level_reg <= pin_sync;
        end else begin
            run_reg   <= (differs && !settle) ? run_reg + 8'h01 : 8'h00;
            level_reg <= settle ? pin_sync : level_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prev_reg <= 1'b1;
            pcnt_reg <= '0;
        end else begin
            prev_reg <= pin_sync;
            pcnt_reg <= (is_pulse && rise) ? pcnt_reg + 1'b1 : pcnt_reg;
        end
    end

    assign level       = level_reg;
    assign pulse_count = pcnt_reg;

endmodule : iocc_debounce

// ---- hdl/iocc_output.sv ----
// Output driver for one digital output channel with activation tracking.
// Assumes source register values arrive on clk.
`timescale 1ns/10ps
module iocc_output
    import iocc_pkg::*;
#(
    parameter int SRC_N = 16
)(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic [SRC_N-1:0] src_regs,
    input  wire logic [3:0]       src_sel,
    input  wire logic [1:0]       map_one,
    input  wire logic [1:0]       map_zero,
    input  wire logic             active_state,
    input  wire logic [31:0]      pulse_len,
    output logic                  closed,
    output logic                  src_bad,
    output logic [CNT_W-1:0]      act_count,
    output logic [CNT_W-1:0]      act_time
);

    iocc_out_state_t   st_reg;
    logic              out_reg;
    logic              srcv_reg;
    logic [31:0]       hold_reg;
    logic [CNT_W-1:0]  acnt_reg;
    logic [CNT_W-1:0]  atime_reg;

    wire logic       sel_ok  = (32'(src_sel) < SRC_N);
    wire logic       src_val = sel_ok ? src_regs[src_sel] : srcv_reg;
    wire logic       chg     = sel_ok && (src_val != srcv_reg);
    wire logic [1:0] map     = src_val ? map_one : map_zero;
    wire logic       mapped  = (map == OUT_CLOSED);
    wire logic       do_map  = chg && (map == OUT_OPEN || map == OUT_CLOSED);
    wire logic       new_out = do_map ? mapped : out_reg;
    wire logic       enter   = do_map && (mapped == active_state) && (out_reg != active_state);
    wire logic       expire  = (st_reg == IOCC_HOLD) && (hold_reg <= 32'h1);

    // A zero duration means the output holds its active state until mapped away.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg   <= IOCC_IDLE;
            out_reg  <= 1'b0;
            srcv_reg <= 1'b0;
            hold_reg <= 32'h0;
        end else begin
            srcv_reg <= src_val;
            case (st_reg)
                IOCC_IDLE: begin
                    out_reg <= new_out;
                    if (enter && pulse_len != 32'h0) begin
                        st_reg   <= IOCC_HOLD;
                        hold_reg <= pulse_len;
                    end
                end
                IOCC_HOLD: begin
                    hold_reg <= hold_reg - 32'h1;
                    if (expire) begin
                        st_reg  <= IOCC_IDLE;
                        out_reg <= !active_state;
                    end
                end
                default: st_reg <= IOCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            acnt_reg  <= '0;
            atime_reg <= '0;
        end else begin
            acnt_reg  <= (new_out == active_state && out_reg != active_state && st_reg == IOCC_IDLE)
                         ? acnt_reg + 1'b1 : acnt_reg;
            atime_reg <= (out_reg == active_state) ? atime_reg + 1'b1 : atime_reg;
        end
    end

    assign closed    = out_reg;
    assign src_bad   = !sel_ok;
    assign act_count = acnt_reg;
    assign act_time  = atime_reg;

endmodule : iocc_output

// ---- hdl/iocc_top.sv ----
// Channel conditioning: one analog, one digital input, one digital output.
// Assumes raw ADC samples arrive with a one-cycle valid strobe on clk.
`timescale 1ns/10ps
module iocc_top
    import iocc_pkg::*;
#(
    parameter int SRC_N = 16
)(
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic [2:0]              ana_range,
    input  wire logic signed [FIX_W-1:0] ana_offset,
    input  wire logic signed [FIX_W-1:0] ana_weight,
    input  wire logic [DMP_W-1:0]        ana_damp,
    input  wire logic [ANA_W-1:0]        ana_raw,
    input  wire logic                    ana_valid,
    output logic signed [FIX_W-1:0]      ana_value,
    output logic                         ana_value_valid,
    input  wire logic                    din_pin,
    input  wire logic [1:0]              din_type,
    input  wire logic [7:0]              din_debounce,
    input  wire logic                    din_pullup_cfg,
    output logic                         din_pullup_en,
    output logic                         din_level,
    output logic [CNT_W-1:0]             din_pulses,
    input  wire logic [SRC_N-1:0]        dout_src_regs,
    input  wire logic [3:0]              dout_src_sel,
    input  wire logic [1:0]              dout_map_one,
    input  wire logic [1:0]              dout_map_zero,
    input  wire logic                    dout_active_state,
    input  wire logic [31:0]             dout_pulse_len,
    output logic                         dout_closed,
    output logic                         dout_src_bad,
    output logic [CNT_W-1:0]             dout_act_count,
    output logic [CNT_W-1:0]             dout_act_time
);

    logic signed [FIX_W-1:0] filt_reg;
    logic                    vld_reg;
    logic                    prime_reg;
    logic                    pull_reg;
    logic [1:0]              pin_sync_reg;

    function automatic logic is_custom(input logic [2:0] code);
        is_custom = (code >= RANGE_CUST_LO) && (code <= RANGE_CUST_HI);
    endfunction : is_custom

    // Raw reading widened to fixed point with FRAC_W fraction bits.
    wire logic signed [63:0] raw_fix  = 64'(signed'({1'b0, ana_raw})) <<< FRAC_W;
    wire logic               cust     = is_custom(ana_range);
    wire logic signed [63:0] wprod    = 64'(signed'({1'b0, ana_raw})) * 64'(ana_weight);
    wire logic signed [63:0] scaled   = cust ? (wprod + 64'(ana_offset)) >>> FRAC_W
                                             : raw_fix >>> FRAC_W;
    wire logic signed [FIX_W-1:0] sample = scaled[FIX_W-1:0];
    wire logic               active   = (ana_range != RANGE_NONE) && (ana_range <= RANGE_CUST_HI);
    // Damping: filt + (1-k)*(sample-filt), k as unsigned Q0.16 fraction.
    wire logic signed [63:0] diff     = 64'(sample) - 64'(filt_reg);
    // The gain is 1.0 minus k exactly, so a zero k passes a sample through unchanged.
    wire logic signed [63:0] step     = (diff * 64'(signed'(18'h1_0000 - 18'(ana_damp)))) >>> DMP_W;
    wire logic signed [FIX_W-1:0] blended = prime_reg ? filt_reg + step[FIX_W-1:0] : sample;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            filt_reg  <= '0;
            vld_reg   <= 1'b0;
            prime_reg <= 1'b0;
        end else begin
            vld_reg <= ana_valid && active;
            if (ana_valid && active) begin
                filt_reg  <= blended;
                prime_reg <= 1'b1;
            end else if (!active) begin
                prime_reg <= 1'b0;
            end
        end
    end

    // Pin is asynchronous to clk, so two flops precede any use.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Reset to the pulled-up idle level, so a release does not fake an edge.
            pin_sync_reg <= 2'h3;
            pull_reg     <= PULLUP_RST;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], din_pin};
            pull_reg     <= din_pullup_cfg;
        end
    end

    iocc_debounce u_deb (
        .clk          (clk),
        .nrst         (nrst),
        .pin_sync     (pin_sync_reg[1]),
        .in_type      (din_type),
        .debounce_cnt (din_debounce),
        .level        (din_level),
        .pulse_count  (din_pulses)
    );

    iocc_output #(.SRC_N(SRC_N)) u_out (
        .clk          (clk),
        .nrst         (nrst),
        .src_regs     (dout_src_regs),
        .src_sel      (dout_src_sel),
        .map_one      (dout_map_one),
        .map_zero     (dout_map_zero),
        .active_state (dout_active_state),
        .pulse_len    (dout_pulse_len),
        .closed       (dout_closed),
        .src_bad      (dout_src_bad),
        .act_count    (dout_act_count),
        .act_time     (dout_act_time)
    );

    assign ana_value       = filt_reg;
    assign ana_value_valid = vld_reg;
    assign din_pullup_en   = pull_reg;

endmodule : iocc_top

// ---- tb/iocc_chk.sv ----
// Port checker for the channel conditioning top level.
// Assumes it is bound to iocc_top and sees only that module's ports.
`timescale 1ns/10ps
module iocc_chk
    import iocc_pkg::*;
#(
    parameter int SRC_N = 16
)(
    input wire logic             clk,
    input wire logic             nrst,
    input wire logic [2:0]       ana_range,
    input wire logic             ana_valid,
    input wire logic             ana_value_valid,
    input wire logic             din_pin,
    input wire logic [1:0]       din_type,
    input wire logic [7:0]       din_debounce,
    input wire logic             din_pullup_cfg,
    input wire logic             din_pullup_en,
    input wire logic             din_level,
    input wire logic [CNT_W-1:0] din_pulses,
    input wire logic [3:0]       dout_src_sel,
    input wire logic [1:0]       dout_map_one,
    input wire logic [1:0]       dout_map_zero,
    input wire logic             dout_active_state,
    input wire logic [31:0]      dout_pulse_len,
    input wire logic             dout_closed,
    input wire logic             dout_src_bad,
    input wire logic [CNT_W-1:0] dout_act_count,
    input wire logic [CNT_W-1:0] dout_act_time
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_pullup_follow: assert property ($past(nrst) |-> din_pullup_en == $past(din_pullup_cfg))
        else $error("pull-up enable does not follow its control");
    a_sel_range: assert property (dout_src_bad == (dout_src_sel >= SRC_N))
        else $error("source flag disagrees with selector");
    a_valid_cause: assert property (ana_value_valid |-> $past(ana_valid) && $past(ana_range) inside {[3'h1:3'h6]})
        else $error("analog strobe without accepted sample");
    a_pulse_step: assert property ($past(nrst) && $changed(din_pulses) |->
        din_pulses == $past(din_pulses) + 32'h1 && $past(din_type) == DI_PULSE)
        else $error("pulse count moved wrongly");
    a_debounce_hold: assert property ($past(din_type, 8) == DI_PLAIN && $past(din_type) == DI_PLAIN
        && din_type == DI_PLAIN && din_debounce >= 8'h02 && $changed(din_level)
        |-> $past(din_pin, 3) == din_level && $past(din_pin, 4) == din_level)
        else $error("level changed on an unsettled pin");
    a_hold_len: assert property ($rose(dout_closed) && dout_active_state && dout_pulse_len == 32'h3 |->
        dout_closed [*3] ##1 !dout_closed)
        else $error("timed hold has wrong length");
    a_count_cause: assert property ($past(nrst) && $changed(dout_act_count) |->
        dout_act_count == $past(dout_act_count) + 32'h1 && dout_closed == dout_active_state)
        else $error("activation count moved wrongly");
    a_time_step: assert property ($past(nrst) && $changed(dout_act_time) |->
        dout_act_time == $past(dout_act_time) + 32'h1)
        else $error("active time moved wrongly");
    a_keep_map: assert property ($past(nrst) && dout_pulse_len == 32'h0 && dout_map_one[1] && dout_map_zero[1]
        && $past(dout_map_one[1] && dout_map_zero[1]) |-> $stable(dout_closed))
        else $error("output moved while both maps keep");
endmodule : iocc_chk

bind iocc_top iocc_chk #(.SRC_N(SRC_N)) u_chk (.*);

// ---- tb/iocc_field.sv ----
// Field contact model on the digital input terminal.
// Assumes the bench commands whether the contact drives or floats.
`timescale 1ns/10ps
module iocc_field (
    input  wire logic clk,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic pullup_en,
    output logic      pin
);
    logic float_reg = 1'h0;
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    // An open contact without pull-up has no level, so it wanders every cycle.
    assign pin = drive_en ? drive_val : (pullup_en ? 1'h1 : float_reg);
endmodule : iocc_field

// ---- tb/testbench.sv ----
// Self-checking bench for the channel conditioning block.
// Assumes a 250 MHz clock and the field model on the digital input.
`timescale 1ns/10ps
module testbench;
    import iocc_pkg::*;
    localparam int SRC_N = 12;
    logic clk = 1'h0, nrst = 1'h0, ana_valid = 1'h0, drive_en = 1'h1, drive_val = 1'h0;
    logic [2:0] ana_range = 3'h2;
    logic signed [FIX_W-1:0] ana_offset = 32'sh0003_0000, ana_weight = 32'sh0002_0000, ana_value;
    logic [DMP_W-1:0] ana_damp = 16'h0;
    logic [ANA_W-1:0] ana_raw = 16'h0100;
    logic ana_value_valid, din_pin, din_pullup_en, din_level, dout_closed, dout_src_bad;
    logic din_pullup_cfg = 1'h1, dout_active_state = 1'h1;
    logic [1:0] din_type = DI_PLAIN, dout_map_one = 2'h1, dout_map_zero = 2'h0;
    logic [7:0] din_debounce = 8'h04;
    logic [SRC_N-1:0] dout_src_regs = 12'h0;
    logic [3:0] dout_src_sel = 4'h3;
    logic [31:0] dout_pulse_len = 32'h0;
    logic [CNT_W-1:0] din_pulses, dout_act_count, dout_act_time, base;
    logic [1:0] mtab [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic etab [4] = '{1'h0, 1'h0, 1'h1, 1'h1};
    int fail_count = 0, n_compared = 0, hi = 0;

    iocc_top #(.SRC_N(SRC_N)) DUT (.*);
    iocc_field field (.clk(clk), .drive_en(drive_en), .drive_val(drive_val), .pullup_en(din_pullup_en), .pin(din_pin));

    always #2 clk = ~clk;
    always @(posedge clk) if (din_level === 1'h1) hi++;

    task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic pin(input logic v, input int n);
        drive_val <= v;
        cyc(n);
    endtask : pin

    // Damping starts at zero, so each accepted sample comes straight through the filter.
    // The offset of 3.0 must only show on the custom codes.
    task automatic ana(input logic [2:0] code, input logic [CNT_W-1:0] exp);
        logic seen;
        seen = 1'h0;
        ana_range <= code;
        ana_valid <= 1'h1;
        @(posedge clk);
        ana_valid <= 1'h0;
        repeat (3) begin
            @(posedge clk);
            if (ana_value_valid === 1'h1) begin
                seen = 1'h1;
                chk(ana_value, exp, "analog value");
            end
        end
        chk(seen, code != 3'h0, "analog strobe");
    endtask : ana

    task automatic close_out();
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #20000;
        fail_count++;
        close_out();
    end

    initial begin
        cyc(10);
        chk({dout_closed, din_pullup_en, din_level, ana_value_valid}, 32'h4, "reset outputs");
        nrst <= 1'h1;
        for (int c = 0; c < 7; c++) ana(c[2:0], (c >= 4) ? 32'h203 : 32'h100);
        ana_damp <= 16'h8000;
        ana_raw <= 16'h0300;
        ana(3'h3, 32'h281);
        pin(1'h0, 10);
        hi = 0;
        pin(1'h1, 2);
        pin(1'h0, 10);
        chk(hi, 0, "glitch passed");
        pin(1'h1, 3);
        chk(din_level, 0, "level early");
        cyc(6);
        chk(din_level, 1, "level late");
        din_type <= DI_NONE;
        pin(1'h0, 10);
        hi = 0;
        pin(1'h1, 2);
        pin(1'h0, 6);
        chk(hi != 0, 1, "unfiltered glitch");
        din_type <= DI_PULSE;
        cyc(5);
        base = din_pulses;
        repeat (3) begin
            pin(1'h1, 2);
            pin(1'h0, 2);
        end
        cyc(3);
        chk(din_pulses, base + 32'h3, "pulse count");
        drive_en <= 1'h0;
        din_pullup_cfg <= 1'h0;
        cyc(3);
        chk(din_pullup_en, 0, "pull-up off");
        din_pullup_cfg <= 1'h1;
        cyc(3);
        chk({din_pullup_en, din_pin}, 32'h3, "pull-up on");
        base = dout_act_count;
        dout_src_regs[3] <= 1'h1;
        cyc(3);
        chk(dout_closed, 1, "source one");
        chk(dout_act_count, base + 32'h1, "activation");
        base = dout_act_time;
        dout_src_regs[3] <= 1'h0;
        cyc(3);
        chk(dout_closed, 0, "source zero");
        chk(dout_act_time, base + 32'h2, "active time");
        dout_map_zero <= 2'h3;
        for (int i = 0; i < 4; i++) begin
            dout_map_one <= mtab[i];
            dout_src_regs[3] <= 1'h0;
            cyc(2);
            dout_src_regs[3] <= 1'h1;
            cyc(3);
            chk(dout_closed, etab[i], "map one");
        end
        dout_map_zero <= 2'h0;
        dout_map_one <= 2'h1;
        dout_pulse_len <= 32'h3;
        dout_src_regs[3] <= 1'h0;
        cyc(3);
        dout_src_regs[3] <= 1'h1;
        cyc(2);
        chk(dout_closed, 1, "hold active");
        cyc(6);
        chk(dout_closed, 0, "hold expiry");
        dout_src_sel <= 4'hC;
        cyc(2);
        chk(dout_src_bad, 1, "bad source");
        dout_src_sel <= 4'hB;
        cyc(2);
        chk(dout_src_bad, 0, "good source");
        nrst <= 1'h0;
        cyc(2);
        chk({dout_act_count, dout_act_time, din_pulses} == '0, 1, "reset counters");
        nrst <= 1'h1;
        cyc(4);
        chk(din_pulses, 0, "edge after reset");
        close_out();
    end
endmodule : testbench
